// [src/hsc_chan.v]
`timescale 1ns/100ps
`include "hsc_defines.vh"
// ==========================================================
// one counting channel
module hsc_chan (
	input wire clk_i,
	input wire arst_n_i,
	input wire a_i,
	input wire b_i,
	input wire m_i,
	input wire [1:0] mode_i,
	input wire mark_pol_i,
	input wire keep_i,
	input wire ring_i,
	input wire cpu_stop_i,
	input wire [31:0] set1_i,
	input wire [31:0] set2_i,
	input wire load_i,
	input wire [31:0] load_val_i,
	output reg [31:0] count_o,
	output reg match_o,
	output reg bad_o
);
	reg a_q;
	reg b_q;
	reg m_q;
	reg up;
	reg dn;
	wire a_rise = a_i & ~a_q;
	wire b_rise = b_i & ~b_q;
	wire a_chg = a_i ^ a_q;
	wire b_chg = b_i ^ b_q;
	wire run = ~cpu_stop_i | keep_i; // [RL8]
	wire mark = mark_pol_i ? (m_i & ~m_q) : (~m_i & m_q); // [RL7]

	// ==========================================================
	// direction decode per mode
	always @* begin
		up = 1'b0;
		dn = 1'b0;
		case (mode_i) // [RL6]
		`HSC_MODE_2PH: begin
			up = a_rise & ~b_i; // [RL13]
			dn = a_rise & b_i; // [RL13]
		end
		`HSC_MODE_CWCCW: begin
			up = a_rise & ~b_rise;
			dn = b_rise & ~a_rise;
		end
		`HSC_MODE_CKUD: begin
			up = a_rise & ~b_i;
			dn = a_rise & b_i;
		end
		default: begin
			up = (a_chg & ~b_chg & (a_i ^ b_i)) |
				(b_chg & ~a_chg & ~(a_i ^ b_i));
			dn = (a_chg & ~b_chg & ~(a_i ^ b_i)) |
				(b_chg & ~a_chg & (a_i ^ b_i));
		end
		endcase
	end

	// ==========================================================
	// counter and match
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			a_q <= 1'b0;
			b_q <= 1'b0;
			m_q <= 1'b0;
			count_o <= 32'h00000000;
			match_o <= 1'b0;
			bad_o <= 1'b0;
		end else begin
			a_q <= a_i;
			b_q <= b_i;
			m_q <= m_i;
			bad_o <= (mode_i == `HSC_MODE_X4) & a_chg & b_chg;
			if (load_i) begin
				count_o <= load_val_i;
			end else if (run & mark) begin
				count_o <= 32'h00000000;
			end else if (run & up) begin
				if (ring_i && count_o == set2_i) begin
					count_o <= 32'h00000000; // [RL15]
				end else begin
					count_o <= count_o + 32'h00000001; // [RL12]
				end
			end else if (run & dn) begin
				if (ring_i && count_o == 32'h00000000) begin
					count_o <= set2_i; // [RL15]
				end else begin
					count_o <= count_o - 32'h00000001; // [RL12]
				end
			end
			match_o <= ring_i ? (count_o == set2_i) :
				(count_o >= set1_i); // [RL14]
		end
	end
endmodule

// [src/hsc_defines.vh]
// Functional notes
// [RL1] power lamp on only when running normally
// [RL2] fault lamp on for internal hardware fault
// [RL3] reset button blinks fault lamp, not latched
// [RL4] per channel lamps follow A, B, marker
// [RL5] one lamp per match terminal
// [RL6] two shared bits select the counting mode
// [RL7] per channel marker edge polarity bit
// [RL8] per channel count or halt during stop
// [RL9] per channel normal or ring counter
// [RL10] test bit runs internal self check pattern
// [RL11] configuring party keeps bit ten off
// [RL12] counts are full 32 bit unsigned
// [RL13] two phase direction from A/B phase order
// [RL14] match on >= set1, ring on == set2
// [RL15] ring counter wraps to zero after set2
// [RL16] switches captured at reset, held fixed
`ifndef HSC_DEFINES_VH
`define HSC_DEFINES_VH
// ==========================================================
// register byte offsets
`define HSC_OFS_CTRL 8'h00
`define HSC_OFS_STAT 8'h04
`define HSC_OFS_CFG 8'h08
`define HSC_OFS_CNT0 8'h10
`define HSC_OFS_CNT1 8'h14
`define HSC_OFS_S1_0 8'h20
`define HSC_OFS_S2_0 8'h24
`define HSC_OFS_S1_1 8'h28
`define HSC_OFS_S2_1 8'h2C
// ==========================================================
// control register fields
`define HSC_CTRL_STOP 0
`define HSC_CTRL_ROUTE0 3
`define HSC_CTRL_ROUTE1 4
`define HSC_CTRL_RST 32'h00000000
// ==========================================================
// status register fields
`define HSC_ST_PWR 0
`define HSC_ST_FAULT 1
`define HSC_ST_CFGOK 2
// ==========================================================
// switch bit positions (bit1 of the switch is index 0)
`define HSC_SW_MODE_LO 0
`define HSC_SW_MODE_HI 1
`define HSC_SW_POL 2
`define HSC_SW_KEEP 4
`define HSC_SW_RING 6
`define HSC_SW_TEST 8
`define HSC_SW_RSVD 9
// ==========================================================
// counting modes {bit1,bit2}
`define HSC_MODE_2PH 2'h0
`define HSC_MODE_CWCCW 2'h1
`define HSC_MODE_CKUD 2'h2
`define HSC_MODE_X4 2'h3
// ==========================================================
// timing and bus response codes
`define HSC_CLK_MHZ 250
`define HSC_BLINK_US 100000
`define HSC_TEST_DIV_US 40
`define HSC_RESP_OKAY 2'h0
`define HSC_RESP_SLVERR 2'h2
`endif

// [src/hsc_sync.v]
`timescale 1ns/100ps
// ==========================================================
// two stage synchroniser for a vector of pin levels
module hsc_sync #(
	parameter W = 1
) (
	input wire clk_i,
	input wire arst_n_i,
	input wire [W-1:0] d_i,
	output reg [W-1:0] q_o
);
	reg [W-1:0] meta_q;
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_q <= {W{1'b0}};
			q_o <= {W{1'b0}};
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule

// [src/hsc_top.v]
`timescale 1ns/100ps
`include "hsc_defines.vh"
// ==========================================================
// high speed counter with AXI4-Lite registers
module hsc_top #(
	parameter NUM_CH = 2,
	parameter BLINK_CYC = `HSC_BLINK_US * `HSC_CLK_MHZ,
	parameter TEST_CYC = `HSC_TEST_DIV_US * `HSC_CLK_MHZ
) (
	input wire clk_i,
	input wire arst_n_i,
	input wire [7:0] s_axi_awaddr_i,
	input wire s_axi_awvalid_i,
	output reg s_axi_awready_o,
	input wire [31:0] s_axi_wdata_i,
	input wire [3:0] s_axi_wstrb_i,
	input wire s_axi_wvalid_i,
	output reg s_axi_wready_o,
	output reg [1:0] s_axi_bresp_o,
	output reg s_axi_bvalid_o,
	input wire s_axi_bready_i,
	input wire [7:0] s_axi_araddr_i,
	input wire s_axi_arvalid_i,
	output reg s_axi_arready_o,
	output reg [31:0] s_axi_rdata_o,
	output reg [1:0] s_axi_rresp_o,
	output reg s_axi_rvalid_o,
	input wire s_axi_rready_i,
	input wire [1:0] phase_a_i,
	input wire [1:0] phase_b_i,
	input wire [1:0] index_i,
	input wire [9:0] cfg_sw_i,
	input wire reset_btn_i,
	output reg power_ok_indicator_o,
	output reg fault_indicator_o,
	output reg ch1_phase_a_indicator_o,
	output reg ch1_phase_b_indicator_o,
	output reg ch1_index_indicator_o,
	output reg ch2_phase_a_indicator_o,
	output reg ch2_phase_b_indicator_o,
	output reg ch2_index_indicator_o,
	output reg match_out_0_o,
	output reg match_out_1_o,
	output reg match_out_2_o,
	output reg match_out_3_o,
	output reg [3:0] match_led_o
);
	// ==========================================================
	// pin synchronisers
	wire [1:0] a_s;
	wire [1:0] b_s;
	wire [1:0] m_s;
	wire [9:0] sw_s;
	wire btn_s;
	hsc_sync #(.W(17)) u_sync (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.d_i({reset_btn_i, cfg_sw_i, index_i, phase_b_i, phase_a_i}),
		.q_o({btn_s, sw_s, m_s, b_s, a_s})
	);

	// ==========================================================
	// switch capture after reset release
	reg [1:0] cap_cnt_q;
	reg cfg_ok_q;
	reg [9:0] cfg_q;
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cap_cnt_q <= 2'h0;
			cfg_ok_q <= 1'b0;
			cfg_q <= 10'h000;
		end else if (!cfg_ok_q) begin
			cap_cnt_q <= cap_cnt_q + 2'h1;
			if (cap_cnt_q == 2'h3) begin
				cfg_q <= sw_s; // [RL16]
				cfg_ok_q <= 1'b1;
			end
		end
	end
	wire [1:0] mode = {cfg_q[`HSC_SW_MODE_LO], cfg_q[`HSC_SW_MODE_HI]};
	wire test_on = cfg_q[`HSC_SW_TEST];

	// ==========================================================
	// self check pattern: slow up-counting quadrature
	reg [31:0] tdiv_q;
	reg [1:0] tgray_q;
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tdiv_q <= 32'h00000000;
			tgray_q <= 2'h0;
		end else if (test_on) begin
			if (tdiv_q == TEST_CYC - 1) begin
				tdiv_q <= 32'h00000000;
				tgray_q <= {~tgray_q[0], tgray_q[1]};
			end else begin
				tdiv_q <= tdiv_q + 32'h00000001;
			end
		end
	end

	// ==========================================================
	// register file
	reg [31:0] ctrl_q;
	reg [31:0] set1_q [0:1];
	reg [31:0] set2_q [0:1];
	reg [1:0] load_q;
	reg [31:0] load_val_q;
	reg fault_q;
	wire [31:0] cnt [0:1];
	wire [1:0] mat;
	wire [1:0] bad;
	reg [7:0] aw_q;
	reg [31:0] wd_q;
	reg [3:0] ws_q;
	reg aw_have_q;
	reg w_have_q;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] st;
		integer k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (st[k]) begin
					merge[k*8 +: 8] = nw[k*8 +: 8];
				end
			end
		end
	endfunction

	wire do_wr = aw_have_q & w_have_q & ~s_axi_bvalid_o;
	wire hw_fault = (|bad) | cfg_q[`HSC_SW_RSVD]; // [RL11]

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o <= 1'b1;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `HSC_RESP_OKAY;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_q <= 8'h00;
			wd_q <= 32'h00000000;
			ws_q <= 4'h0;
			ctrl_q <= `HSC_CTRL_RST;
			set1_q[0] <= 32'h00000000;
			set1_q[1] <= 32'h00000000;
			set2_q[0] <= 32'h00000000;
			set2_q[1] <= 32'h00000000;
			load_q <= 2'h0;
			load_val_q <= 32'h00000000;
			fault_q <= 1'b0;
		end else begin
			load_q <= 2'h0;
			if (s_axi_awvalid_i & s_axi_awready_o) begin
				aw_q <= s_axi_awaddr_i;
				aw_have_q <= 1'b1;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i & s_axi_wready_o) begin
				wd_q <= s_axi_wdata_i;
				ws_q <= s_axi_wstrb_i;
				w_have_q <= 1'b1;
				s_axi_wready_o <= 1'b0;
			end
			if (s_axi_bvalid_o & s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o <= 1'b1;
			end
			// sticky fault: a new fault wins over the clearing write
			if (hw_fault) begin
				fault_q <= 1'b1; // [RL2]
			end else if (do_wr && aw_q == `HSC_OFS_STAT &&
				ws_q[0] && wd_q[`HSC_ST_FAULT]) begin
				fault_q <= 1'b0;
			end
			if (do_wr) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= `HSC_RESP_OKAY;
				load_val_q <= merge(cnt[aw_q[2]], wd_q, ws_q);
				if (aw_q == `HSC_OFS_CTRL) begin
					ctrl_q <= merge(ctrl_q, wd_q, ws_q) & 32'h0000001F;
				end else if (aw_q == `HSC_OFS_STAT) begin
					ctrl_q <= ctrl_q;
				end else if (aw_q == `HSC_OFS_CNT0) begin
					load_q <= 2'h1;
				end else if (aw_q == `HSC_OFS_CNT1) begin
					load_q <= 2'h2;
				end else if (aw_q == `HSC_OFS_S1_0) begin
					set1_q[0] <= merge(set1_q[0], wd_q, ws_q);
				end else if (aw_q == `HSC_OFS_S2_0) begin
					set2_q[0] <= merge(set2_q[0], wd_q, ws_q);
				end else if (aw_q == `HSC_OFS_S1_1) begin
					set1_q[1] <= merge(set1_q[1], wd_q, ws_q);
				end else if (aw_q == `HSC_OFS_S2_1) begin
					set2_q[1] <= merge(set2_q[1], wd_q, ws_q);
				end else if (aw_q != `HSC_OFS_CFG) begin
					s_axi_bresp_o <= `HSC_RESP_SLVERR;
				end
			end
		end
	end

	// ==========================================================
	// channels
	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1) begin : g_ch
			if (i < NUM_CH) begin : g_on
				hsc_chan u_chan (
					.clk_i(clk_i),
					.arst_n_i(arst_n_i),
					.a_i(test_on ? tgray_q[1] : a_s[i]), // [RL10]
					.b_i(test_on ? tgray_q[0] : b_s[i]), // [RL10]
					.m_i(test_on ? 1'b0 : m_s[i]),
					.mode_i(mode), // [RL6]
					.mark_pol_i(cfg_q[`HSC_SW_POL + i]), // [RL7]
					.keep_i(cfg_q[`HSC_SW_KEEP + i]), // [RL8]
					.ring_i(cfg_q[`HSC_SW_RING + i]), // [RL9]
					.cpu_stop_i(ctrl_q[`HSC_CTRL_STOP]),
					.set1_i(set1_q[i]),
					.set2_i(set2_q[i]),
					.load_i(load_q[i]),
					.load_val_i(load_val_q),
					.count_o(cnt[i]),
					.match_o(mat[i]),
					.bad_o(bad[i])
				);
			end else begin : g_off
				assign cnt[i] = 32'h00000000;
				assign mat[i] = 1'b0;
				assign bad[i] = 1'b0;
			end
		end
	endgenerate

	// ==========================================================
	// read channel
	reg [31:0] rd;
	reg rd_ok;
	always @* begin
		rd = 32'h00000000;
		rd_ok = 1'b1;
		if (s_axi_araddr_i == `HSC_OFS_CTRL) begin
			rd = ctrl_q;
		end else if (s_axi_araddr_i == `HSC_OFS_STAT) begin
			rd = {19'h00000, match_led_o, ch2_index_indicator_o,
				ch2_phase_b_indicator_o, ch2_phase_a_indicator_o,
				ch1_index_indicator_o, ch1_phase_b_indicator_o,
				ch1_phase_a_indicator_o, 3'h0};
			rd[`HSC_ST_PWR] = power_ok_indicator_o;
			rd[`HSC_ST_FAULT] = fault_q;
			rd[`HSC_ST_CFGOK] = cfg_ok_q;
		end else if (s_axi_araddr_i == `HSC_OFS_CFG) begin
			rd = {22'h000000, cfg_q};
		end else if (s_axi_araddr_i == `HSC_OFS_CNT0) begin
			rd = cnt[0];
		end else if (s_axi_araddr_i == `HSC_OFS_CNT1) begin
			rd = cnt[1];
		end else if (s_axi_araddr_i == `HSC_OFS_S1_0) begin
			rd = set1_q[0];
		end else if (s_axi_araddr_i == `HSC_OFS_S2_0) begin
			rd = set2_q[0];
		end else if (s_axi_araddr_i == `HSC_OFS_S1_1) begin
			rd = set1_q[1];
		end else if (s_axi_araddr_i == `HSC_OFS_S2_1) begin
			rd = set2_q[1];
		end else begin
			rd_ok = 1'b0;
		end
	end

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h00000000;
			s_axi_rresp_o <= `HSC_RESP_OKAY;
		end else if (s_axi_arvalid_i & s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o <= rd;
			s_axi_rresp_o <= rd_ok ? `HSC_RESP_OKAY : `HSC_RESP_SLVERR;
		end else if (s_axi_rvalid_o & s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end

	// ==========================================================
	// reset button blink, lamps and match terminals
	reg [31:0] blink_q;
	reg btn_q;
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			blink_q <= 32'h00000000;
			btn_q <= 1'b0;
			power_ok_indicator_o <= 1'b0;
			fault_indicator_o <= 1'b0;
			ch1_phase_a_indicator_o <= 1'b0;
			ch1_phase_b_indicator_o <= 1'b0;
			ch1_index_indicator_o <= 1'b0;
			ch2_phase_a_indicator_o <= 1'b0;
			ch2_phase_b_indicator_o <= 1'b0;
			ch2_index_indicator_o <= 1'b0;
			match_out_0_o <= 1'b0;
			match_out_1_o <= 1'b0;
			match_out_2_o <= 1'b0;
			match_out_3_o <= 1'b0;
			match_led_o <= 4'h0;
		end else begin
			btn_q <= btn_s;
			if (btn_s & ~btn_q) begin
				blink_q <= BLINK_CYC; // [RL3]
			end else if (blink_q != 32'h00000000) begin
				blink_q <= blink_q - 32'h00000001;
			end
			// blink lights the lamp only; fault_q is left alone
			fault_indicator_o <= fault_q |
				(blink_q != 32'h00000000); // [RL2] [RL3]
			power_ok_indicator_o <= cfg_ok_q & ~fault_q & ~test_on; // [RL1]
			ch1_phase_a_indicator_o <= a_s[0]; // [RL4]
			ch1_phase_b_indicator_o <= b_s[0]; // [RL4]
			ch1_index_indicator_o <= m_s[0]; // [RL4]
			ch2_phase_a_indicator_o <= (NUM_CH > 1) & a_s[1]; // [RL4]
			ch2_phase_b_indicator_o <= (NUM_CH > 1) & b_s[1]; // [RL4]
			ch2_index_indicator_o <= (NUM_CH > 1) & m_s[1]; // [RL4]
			match_out_0_o <= mat[0] & ~ctrl_q[`HSC_CTRL_ROUTE0];
			match_out_1_o <= mat[0] & ctrl_q[`HSC_CTRL_ROUTE0];
			match_out_2_o <= mat[1] & ~ctrl_q[`HSC_CTRL_ROUTE1];
			match_out_3_o <= mat[1] & ctrl_q[`HSC_CTRL_ROUTE1];
			match_led_o <= {mat[1] & ctrl_q[`HSC_CTRL_ROUTE1],
				mat[1] & ~ctrl_q[`HSC_CTRL_ROUTE1],
				mat[0] & ctrl_q[`HSC_CTRL_ROUTE0],
				mat[0] & ~ctrl_q[`HSC_CTRL_ROUTE0]}; // [RL5]
		end
	end
endmodule

// [test/hsc_enc_model.sv]
`timescale 1ns/100ps
// ==========================================================
// encoder and pulse source on the far side of the counter pins
module hsc_enc_model #(
	parameter HOLD = 6
) (
	input wire clk_i,
	output reg [1:0] phase_a_o,
	output reg [1:0] phase_b_o,
	output reg [1:0] index_o
);
	initial begin
		phase_a_o = 2'h0;
		phase_b_o = 2'h0;
		index_o = 2'h0;
	end
	// every level is held long enough to clear the pin synchroniser
	task hold;
		begin
			repeat (HOLD) @(posedge clk_i);
		end
	endtask
	// one full cycle: a leads b by a quarter period going up
	task quad(input integer ch, input reg up);
		integer s;
		begin
			for (s = 0; s < 4; s = s + 1) begin
				phase_a_o[ch] <= up ? (s < 2) : (s == 1 || s == 2);
				phase_b_o[ch] <= up ? (s == 1 || s == 2) : (s < 2);
				hold;
			end
		end
	endtask
	// single pulse on a (sel low) or b (sel high)
	task pulse(input integer ch, input reg sel);
		begin
			phase_a_o[ch] <= !sel;
			phase_b_o[ch] <= sel;
			hold;
			phase_a_o[ch] <= 1'b0;
			phase_b_o[ch] <= 1'b0;
			hold;
		end
	endtask
	task set_ab(input integer ch, input reg a, input reg b);
		begin
			phase_a_o[ch] <= a;
			phase_b_o[ch] <= b;
			hold;
		end
	endtask
	task mark(input integer ch, input reg v);
		begin
			index_o[ch] <= v;
			hold;
		end
	endtask
endmodule

// [test/hsc_top_props.sv]
`timescale 1ns/100ps
// ==========================================================
// port checker for the counter top
module hsc_top_props (
	input wire clk_i,
	input wire arst_n_i,
	input wire s_axi_awvalid_i,
	input wire s_axi_awready_o,
	input wire s_axi_wvalid_i,
	input wire s_axi_wready_o,
	input wire s_axi_bvalid_o,
	input wire s_axi_arvalid_i,
	input wire s_axi_arready_o,
	input wire s_axi_rvalid_o,
	input wire [1:0] phase_a_i,
	input wire [1:0] index_i,
	input wire [9:0] cfg_sw_i,
	input wire power_ok_indicator_o,
	input wire fault_indicator_o,
	input wire ch1_phase_a_indicator_o,
	input wire ch1_index_indicator_o,
	input wire match_out_0_o,
	input wire [3:0] match_led_o
);
	// ==========================================================
	// settle time after reset, switches captured well before it ends
	reg [3:0] up_q;
	wire up_w;
	assign up_w = (up_q == 4'hF);
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			up_q <= 4'h0;
		end else if (!up_w) begin
			up_q <= up_q + 4'h1;
		end
	end
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);
	pwr_test_off_a: assert property (
		up_w && cfg_sw_i[8] |-> !power_ok_indicator_o)
		else $error("power lamp lit in test mode");
	pwr_normal_on_a: assert property (
		up_w && cfg_sw_i[9:8] == 2'h0 && !fault_indicator_o
		|-> power_ok_indicator_o) else $error("power lamp dark");
	fault_lamp_a: assert property (
		up_w && cfg_sw_i[9] |-> fault_indicator_o)
		else $error("fault lamp dark on fault");
	lamp_a_rise_a: assert property (
		up_w && !cfg_sw_i[8] && $rose(phase_a_i[0])
		|-> ##[2:5] ch1_phase_a_indicator_o) else $error("a lamp late");
	lamp_m_fall_a: assert property (
		up_w && !cfg_sw_i[8] && $fell(index_i[0])
		|-> ##[2:5] !ch1_index_indicator_o) else $error("m lamp late");
	led_follow_a: assert property (
		match_out_0_o |-> ##[0:2] match_led_o[0])
		else $error("terminal lamp dark");
	b_delay_a: assert property (s_axi_awvalid_i && s_axi_awready_o
		&& s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
		else $error("write response late");
	r_delay_a: assert property (
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read data late");
	r_busy_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read taken while busy");
endmodule

// [test/hsc_top_test.sv]
`timescale 1ns/100ps
`include "hsc_defines.vh"
// ==========================================================
// self checking bench for the counter top
module hsc_top_test;
	reg clk_i, arst_n_i, reset_btn_i, ta, tw, got;
	reg s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
	reg s_axi_arvalid_i, s_axi_rready_i;
	reg [7:0] s_axi_awaddr_i, s_axi_araddr_i;
	reg [31:0] s_axi_wdata_i, rdat;
	reg [3:0] s_axi_wstrb_i;
	reg [9:0] cfg_sw_i;
	reg [1:0] resp_seen;
	integer bad_count, compares;
	wire [1:0] phase_a_i, phase_b_i, index_i, s_axi_bresp_o, s_axi_rresp_o;
	wire [31:0] s_axi_rdata_o;
	wire [3:0] match_led_o;
	wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	wire s_axi_arready_o, s_axi_rvalid_o, power_ok_indicator_o;
	wire fault_indicator_o, ch1_phase_a_indicator_o, ch1_phase_b_indicator_o;
	wire ch1_index_indicator_o, ch2_phase_a_indicator_o;
	wire ch2_phase_b_indicator_o, ch2_index_indicator_o;
	wire match_out_0_o, match_out_1_o, match_out_2_o, match_out_3_o;
	hsc_top #(.NUM_CH(2), .BLINK_CYC(20), .TEST_CYC(4)) i_dut (.*);
	hsc_enc_model #(.HOLD(6)) i_enc (.clk_i(clk_i), .phase_a_o(phase_a_i),
		.phase_b_o(phase_b_i), .index_o(index_i));
	// ==========================================================
	// reporting
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
			end
		end
	endtask
	task test_done;
		begin
			$display("compares %0d bad_count %0d", compares, bad_count);
			if (bad_count == 0 && compares > 0) begin
				$display("TB: PASS");
			end else begin
				$display("TB: FAIL");
			end
			$finish;
		end
	endtask
	task lost;
		begin
			bad_count = bad_count + 1;
			$display("wrong value at %0t: bus gave no answer", $time);
			test_done;
		end
	endtask
	// ==========================================================
	// bus master and reset
	task wr(input [7:0] a, input [31:0] d);
		integer n;
		begin
			got = 1'b0;
			@(posedge clk_i);
			s_axi_awaddr_i <= a;
			s_axi_wdata_i <= d;
			s_axi_wstrb_i <= 4'hF;
			s_axi_awvalid_i <= 1'b1;
			s_axi_wvalid_i <= 1'b1;
			s_axi_bready_i <= 1'b1;
			for (n = 0; n < 50 && !got; n = n + 1) begin
				@(negedge clk_i);
				ta = s_axi_awvalid_i && s_axi_awready_o;
				tw = s_axi_wvalid_i && s_axi_wready_o;
				got = s_axi_bvalid_o;
				resp_seen = s_axi_bresp_o;
				@(posedge clk_i);
				if (ta) s_axi_awvalid_i <= 1'b0;
				if (tw) s_axi_wvalid_i <= 1'b0;
				if (got) s_axi_bready_i <= 1'b0;
			end
			if (!got) lost;
		end
	endtask
	task rd(input [7:0] a);
		integer n;
		begin
			got = 1'b0;
			@(posedge clk_i);
			s_axi_araddr_i <= a;
			s_axi_arvalid_i <= 1'b1;
			s_axi_rready_i <= 1'b1;
			for (n = 0; n < 50 && !got; n = n + 1) begin
				@(negedge clk_i);
				ta = s_axi_arvalid_i && s_axi_arready_o;
				got = s_axi_rvalid_o;
				rdat = s_axi_rdata_o;
				resp_seen = s_axi_rresp_o;
				@(posedge clk_i);
				if (ta) s_axi_arvalid_i <= 1'b0;
				if (got) s_axi_rready_i <= 1'b0;
			end
			if (!got) lost;
		end
	endtask
	task rst(input [9:0] sw);
		begin
			cfg_sw_i <= sw; // bit ten set only to provoke a fault
			arst_n_i <= 1'b0;
			repeat (2) @(posedge clk_i);
			arst_n_i <= 1'b1;
			repeat (10) @(posedge clk_i);
		end
	endtask
	// ==========================================================
	// scenarios
	task t_modes;
		integer m, k;
		reg [31:0] x;
		begin
			for (m = 0; m < 4; m = m + 1) begin
				rst({8'h00, m[0], m[1]});
				x = (m == 3) ? 32'h4 : 32'h1;
				if (m == 1) i_enc.pulse(0, 1'b1);
				else i_enc.quad(0, 1'b0);
				rd(`HSC_OFS_CNT0);
				chk(rdat, 32'h0 - x);
				for (k = 0; k < 3; k = k + 1) begin
					if (m == 1) i_enc.pulse(0, 1'b0);
					else i_enc.quad(0, 1'b1);
				end
				rd(`HSC_OFS_CNT0);
				chk(rdat, x * 2);
			end
			$display("modes done");
		end
	endtask
	task t_mark;
		integer p;
		begin
			for (p = 0; p < 2; p = p + 1) begin
				rst(p ? 10'h004 : 10'h000);
				i_enc.quad(0, 1'b1);
				i_enc.quad(0, 1'b1);
				i_enc.mark(0, 1'b1);
				rd(`HSC_OFS_CNT0);
				chk(rdat, p ? 32'h0 : 32'h2);
				i_enc.mark(0, 1'b0);
				rd(`HSC_OFS_CNT0);
				chk(rdat, 32'h0);
			end
			$display("marker done");
		end
	endtask
	task t_stop;
		begin
			rst(10'h020);
			wr(`HSC_OFS_CTRL, 32'h1);
			i_enc.quad(0, 1'b1);
			i_enc.quad(1, 1'b1);
			rd(`HSC_OFS_CNT0);
			chk(rdat, 32'h0);
			rd(`HSC_OFS_CNT1);
			chk(rdat, 32'h1);
			wr(`HSC_OFS_CTRL, 32'h0);
			i_enc.quad(0, 1'b1);
			rd(`HSC_OFS_CNT0);
			chk(rdat, 32'h1);
			$display("stop done");
		end
	endtask
	task t_ring;
		begin
			rst(10'h040);
			wr(`HSC_OFS_S2_0, 32'h2);
			wr(`HSC_OFS_S1_1, 32'h1);
			i_enc.quad(0, 1'b1);
			i_enc.quad(0, 1'b1);
			i_enc.quad(1, 1'b1);
			chk(match_out_0_o, 1);
			chk(match_out_2_o, 1);
			chk(match_led_o, 4'h5);
			wr(`HSC_OFS_CTRL, 32'h8);
			repeat (4) @(posedge clk_i);
			chk({match_out_1_o, match_out_0_o}, 2'h2);
			chk(match_led_o, 4'h6);
			wr(`HSC_OFS_CTRL, 32'h0);
			i_enc.quad(0, 1'b1);
			rd(`HSC_OFS_CNT0);
			chk(rdat, 32'h0);
			chk(match_out_0_o, 0);
			i_enc.quad(1, 1'b1);
			chk(match_out_2_o, 1);
			wr(`HSC_OFS_CTRL, 32'h10);
			repeat (4) @(posedge clk_i);
			chk({match_out_3_o, match_out_2_o}, 2'h2);
			$display("ring done");
		end
	endtask
	task t_btn;
		integer n;
		begin
			rst(10'h000);
			reset_btn_i <= 1'b1;
			repeat (6) @(posedge clk_i);
			reset_btn_i <= 1'b0;
			for (n = 0; n < 10 && fault_indicator_o !== 1'b1; n = n + 1)
				@(negedge clk_i);
			chk(fault_indicator_o, 1);
			repeat (40) @(posedge clk_i);
			chk(fault_indicator_o, 0);
			rd(`HSC_OFS_STAT);
			chk(rdat[1:0], 2'h1);
			$display("button done");
		end
	endtask
	task t_lamps;
		begin
			rst(10'h000);
			i_enc.set_ab(0, 1'b0, 1'b1);
			i_enc.set_ab(1, 1'b1, 1'b1);
			i_enc.mark(1, 1'b1);
			chk(ch1_phase_b_indicator_o, 1);
			chk({ch2_index_indicator_o, ch2_phase_b_indicator_o,
				ch2_phase_a_indicator_o}, 3'h7);
			rd(`HSC_OFS_STAT);
			chk(rdat[8:3], 6'h3A);
			i_enc.set_ab(0, 1'b0, 1'b0);
			i_enc.set_ab(1, 1'b0, 1'b0);
			i_enc.mark(1, 1'b0);
			chk(ch2_phase_a_indicator_o, 0);
			$display("lamps done");
		end
	endtask
	task t_flags;
		reg [31:0] x;
		begin
			rst(10'h200);
			chk(fault_indicator_o, 1);
			chk(power_ok_indicator_o, 0);
			rd(`HSC_OFS_STAT);
			chk(rdat[1], 1);
			wr(`HSC_OFS_STAT, 32'h2);
			rd(`HSC_OFS_STAT);
			chk(rdat[1], 1);
			rst(10'h100);
			rd(`HSC_OFS_CNT0);
			x = rdat;
			repeat (100) @(posedge clk_i);
			rd(`HSC_OFS_CNT0);
			chk(rdat > x, 1);
			chk(power_ok_indicator_o, 0);
			$display("fault and test done");
		end
	endtask
	task t_cfg;
		begin
			rst(10'h0AA);
			rd(`HSC_OFS_CFG);
			chk(rdat, 32'h0AA);
			chk(resp_seen, `HSC_RESP_OKAY);
			cfg_sw_i <= 10'h055;
			wr(`HSC_OFS_CFG, 32'h3FF);
			chk(resp_seen, `HSC_RESP_OKAY);
			rd(`HSC_OFS_CFG);
			chk(rdat, 32'h0AA);
			wr(8'h40, 32'h1);
			chk(resp_seen, `HSC_RESP_SLVERR);
			rd(8'h40);
			chk(resp_seen, `HSC_RESP_SLVERR);
			chk(power_ok_indicator_o, 1);
			$display("config done");
		end
	endtask
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		bad_count = 0;
		compares = 0;
		arst_n_i = 1'b0;
		cfg_sw_i = 10'h000;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 3'h0;
		{s_axi_arvalid_i, s_axi_rready_i, reset_btn_i} = 3'h0;
		{s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, s_axi_wstrb_i} = 52'h0;
		t_modes;
		t_mark;
		t_stop;
		t_ring;
		t_btn;
		t_lamps;
		t_flags;
		t_cfg;
		test_done;
	end
endmodule
bind hsc_top hsc_top_props i_props (.*);
